/* hdl/mc_log_pkg.sv */
// Constants for the machine-check error logging banks
package mc_log_pkg;
  // Register offsets on the plain register port
  localparam logic [3:0] OFF_BANK0_STATUS = 4'h0;
  localparam logic [3:0] OFF_BANK1_STATUS = 4'h1;
  localparam logic [3:0] OFF_IRQ_STATUS = 4'h2;
  localparam logic [3:0] OFF_IRQ_MASK = 4'h3;
  localparam logic [3:0] OFF_CTRL = 4'h4;
  // Status field positions
  localparam int VAL_BIT = 63;
  localparam int OVF_BIT = 62;
  localparam int UC_BIT = 61;
  localparam int CODE_LSB = 0;
  localparam int CODE_W = 16;
  localparam int TTYPE_LSB = 4;
  localparam int TTYPE_W = 4;
  // Request sub-field encodings in the compound error code
  localparam logic [3:0] REQ_DATA_READ = 4'h3;
  localparam logic [3:0] REQ_DATA_WRITE = 4'h4;
  localparam logic [3:0] REQ_PREFETCH = 4'h5;
  // Request kinds seen by the logging logic
  typedef enum logic [2:0] {
    KIND_READ = 3'h0,
    KIND_STORE = 3'h1,
    KIND_OWN_READ = 3'h3,
    KIND_LOCKED_OWN_READ = 3'h2,
    KIND_PREFETCH = 3'h6
  } req_kind_e;
  // Reset values
  localparam logic [63:0] STATUS_RST = 64'h0;
  localparam logic [1:0] IRQ_RST = 2'h0;
  localparam logic [1:0] CTRL_RST = 2'h3;
  // Interrupt status bits
  localparam int IRQ_BANK0 = 0;
  localparam int IRQ_BANK1 = 1;
endpackage : mc_log_pkg

/* hdl/machine_check_error_log_bank.sv */
// Machine-check error logging banks zero and one with interrupt
//
// Function
// - New error while valid set raises bank-zero overflow bit 62.
// - Uncorrectable held error freezes status fields; later errors only set overflow bit 62.
// - After uncorrectable capture, further errors keep overflow set until cleared.
// - Error code updates only together with the rest of the register.
// - Speculative load with correctable cache error leaves bank one untouched.
// - Store with double-bit cache error logs request as store, not prefetch.
// - Correctable error on ownership reads never stalls system bus issue.
// - Bank-one uncorrectable transaction type bits 7-4: 0011b read, 0100b write.
// - Bank-one bit 61 reports an uncorrectable error was received.
`timescale 1ns/1ps
module machine_check_error_log_bank (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [63:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [63:0] reg_rdata_o,
  // Bank-zero error report from the bus/interconnect checker
  input wire logic err0_valid_i,
  input wire logic err0_uc_i,
  input wire logic [2:0] err0_kind_i,
  input wire logic [15:0] err0_code_i,
  // Bank-one error report from the second-level cache
  input wire logic err1_valid_i,
  input wire logic err1_uc_i,
  input wire logic err1_spec_i,
  input wire logic [2:0] err1_kind_i,
  input wire logic [15:0] err1_code_i,
  // Bus issue gating
  input wire logic bus_req_i,
  output logic bus_issue_o,
  // Interrupt
  output logic irq_o
);

  logic [63:0] bank0_status;
  logic [63:0] bank1_status;
  logic [63:0] next_bank0_status;
  logic [63:0] next_bank1_status;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [1:0] ctrl;
  logic [1:0] next_irq_status;
  logic [1:0] next_irq_mask;
  logic [1:0] next_ctrl;
  logic [63:0] next_rdata;
  logic log0_en;
  logic log1_en;

  // Request sub-field from the request kind
  function automatic logic [3:0] req_code(input logic [2:0] kind);
    logic [3:0] r;
    r = mc_log_pkg::REQ_DATA_READ;
    case (kind)
      mc_log_pkg::KIND_STORE: r = mc_log_pkg::REQ_DATA_WRITE;
      mc_log_pkg::KIND_PREFETCH: r = mc_log_pkg::REQ_PREFETCH;
      default: r = mc_log_pkg::REQ_DATA_READ;
    endcase
    return r;
  endfunction : req_code

  // One bank update; the whole record is written at once so that the
  // error code can never drift away from the other fields.
  function automatic logic [63:0] bank_update(
    input logic [63:0] cur,
    input logic uc,
    input logic [2:0] kind,
    input logic [15:0] code
  );
    logic [63:0] n;
    n = cur;
    if (cur[mc_log_pkg::VAL_BIT]) begin
      n[mc_log_pkg::OVF_BIT] = 1'b1;
      if (!cur[mc_log_pkg::UC_BIT]) begin
        // Held correctable error is replaced by the newer one
        n[mc_log_pkg::UC_BIT] = uc;
        n[mc_log_pkg::CODE_LSB +: mc_log_pkg::CODE_W] = code;
        n[mc_log_pkg::TTYPE_LSB +: mc_log_pkg::TTYPE_W] = req_code(kind);
      end
      // Held uncorrectable: fields frozen, overflow kept
    end else begin
      n[mc_log_pkg::VAL_BIT] = 1'b1;
      n[mc_log_pkg::UC_BIT] = uc;
      n[mc_log_pkg::CODE_LSB +: mc_log_pkg::CODE_W] = code;
      n[mc_log_pkg::TTYPE_LSB +: mc_log_pkg::TTYPE_W] = req_code(kind);
    end
    return n;
  endfunction : bank_update

  // Speculative correctable errors are dropped before bank one
  always_comb begin
    log0_en = err0_valid_i && ctrl[0];
    log1_en = err1_valid_i && ctrl[1] && !(err1_spec_i && !err1_uc_i);
  end

  // Correctable errors never hold back the bus, ownership reads included
  always_comb begin
    bus_issue_o = bus_req_i;
  end

  always_comb begin
    next_bank0_status = bank0_status;
    next_bank1_status = bank1_status;
    next_irq_status = irq_status;
    next_irq_mask = irq_mask;
    next_ctrl = ctrl;
    next_rdata = 64'h0;
    if (reg_wr_i) begin
      case (reg_addr_i)
        mc_log_pkg::OFF_BANK0_STATUS: next_bank0_status = reg_wdata_i;
        mc_log_pkg::OFF_BANK1_STATUS: next_bank1_status = reg_wdata_i;
        mc_log_pkg::OFF_IRQ_STATUS: next_irq_status = irq_status & ~reg_wdata_i[1:0];
        mc_log_pkg::OFF_IRQ_MASK: next_irq_mask = reg_wdata_i[1:0];
        mc_log_pkg::OFF_CTRL: next_ctrl = reg_wdata_i[1:0];
        default: ;
      endcase
    end
    // Hardware logging wins over a same-cycle software write
    if (log0_en) begin
      next_bank0_status = bank_update(bank0_status, err0_uc_i, err0_kind_i,
                                      err0_code_i);
      next_irq_status[mc_log_pkg::IRQ_BANK0] = 1'b1;
    end
    if (log1_en) begin
      next_bank1_status = bank_update(bank1_status, err1_uc_i, err1_kind_i,
                                      err1_code_i);
      next_irq_status[mc_log_pkg::IRQ_BANK1] = 1'b1;
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        mc_log_pkg::OFF_BANK0_STATUS: next_rdata = bank0_status;
        mc_log_pkg::OFF_BANK1_STATUS: next_rdata = bank1_status;
        mc_log_pkg::OFF_IRQ_STATUS: next_rdata = {62'h0, irq_status};
        mc_log_pkg::OFF_IRQ_MASK: next_rdata = {62'h0, irq_mask};
        mc_log_pkg::OFF_CTRL: next_rdata = {62'h0, ctrl};
        default: next_rdata = 64'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      bank0_status <= mc_log_pkg::STATUS_RST;
      bank1_status <= mc_log_pkg::STATUS_RST;
      irq_status <= mc_log_pkg::IRQ_RST;
      irq_mask <= mc_log_pkg::IRQ_RST;
      ctrl <= mc_log_pkg::CTRL_RST;
      reg_rdata_o <= 64'h0;
    end else begin
      bank0_status <= next_bank0_status;
      bank1_status <= next_bank1_status;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      ctrl <= next_ctrl;
      reg_rdata_o <= next_rdata;
    end
  end

  always_comb begin
    irq_o = |(irq_status & irq_mask);
  end

  // Checks
  overflow_set_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    log0_en && bank0_status[mc_log_pkg::VAL_BIT]
    |=> bank0_status[mc_log_pkg::OVF_BIT])
    else $error("overflow not set on second error");
  uc_freeze_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    bank0_status[mc_log_pkg::UC_BIT] && bank0_status[mc_log_pkg::VAL_BIT]
    && !reg_wr_i |=> $stable(bank0_status[61:0]))
    else $error("uncorrectable record changed");
  code_stable_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    bank0_status[mc_log_pkg::UC_BIT] && bank0_status[mc_log_pkg::VAL_BIT]
    && !reg_wr_i |=> $stable(bank0_status[15:0]))
    else $error("error code rewritten alone");
  ovf_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    bank0_status[mc_log_pkg::OVF_BIT] && !reg_wr_i
    |=> bank0_status[mc_log_pkg::OVF_BIT])
    else $error("overflow dropped without clear");
  spec_skip_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    err1_valid_i && err1_spec_i && !err1_uc_i && !reg_wr_i
    |=> $stable(bank1_status))
    else $error("speculative correctable error logged");
  store_code_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    log1_en && !bank1_status[mc_log_pkg::VAL_BIT]
    && err1_kind_i == mc_log_pkg::KIND_STORE
    |=> bank1_status[7:4] == mc_log_pkg::REQ_DATA_WRITE)
    else $error("store not logged as write");
  read_code_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    log1_en && !bank1_status[mc_log_pkg::VAL_BIT] && err1_uc_i
    && err1_kind_i == mc_log_pkg::KIND_READ
    |=> bank1_status[7:4] == mc_log_pkg::REQ_DATA_READ)
    else $error("read not logged as 0011b");
  uc_flag_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    log1_en && !bank1_status[mc_log_pkg::VAL_BIT] && err1_uc_i
    |=> bank1_status[mc_log_pkg::UC_BIT])
    else $error("uncorrectable flag missing");
  bus_free_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    bus_req_i |-> bus_issue_o)
    else $error("bus issue stalled");
  sw_clear_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    reg_wr_i && reg_addr_i == mc_log_pkg::OFF_BANK0_STATUS
    && reg_wdata_i == 64'h0 && !log0_en |=> bank0_status == 64'h0)
    else $error("status clear failed");
  // Bank one shares the update function, so its record is held to the same
  ovf1_set_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    log1_en && bank1_status[mc_log_pkg::VAL_BIT]
    |=> bank1_status[mc_log_pkg::OVF_BIT])
    else $error("bank one overflow not set");
  uc1_freeze_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    bank1_status[mc_log_pkg::UC_BIT] && bank1_status[mc_log_pkg::VAL_BIT]
    && !reg_wr_i |=> $stable(bank1_status[61:0]))
    else $error("bank one uncorrectable record changed");
  ovf1_hold_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    bank1_status[mc_log_pkg::OVF_BIT] && !reg_wr_i
    |=> bank1_status[mc_log_pkg::OVF_BIT])
    else $error("bank one overflow dropped without clear");
  code1_stable_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    bank1_status[mc_log_pkg::UC_BIT] && bank1_status[mc_log_pkg::VAL_BIT]
    && !reg_wr_i |=> $stable(bank1_status[15:0]))
    else $error("bank one error code rewritten alone");
  clear1_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    reg_wr_i && reg_addr_i == mc_log_pkg::OFF_BANK1_STATUS
    && reg_wdata_i == 64'h0 && !log1_en |=> bank1_status == 64'h0)
    else $error("bank one clear failed");
  ovf0_clear_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    reg_wr_i && reg_addr_i == mc_log_pkg::OFF_BANK0_STATUS
    && !reg_wdata_i[62] && !log0_en |=> !bank0_status[mc_log_pkg::OVF_BIT])
    else $error("overflow survived clear");
  first0_code_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    log0_en && !bank0_status[mc_log_pkg::VAL_BIT]
    |=> bank0_status[15:8] == $past(err0_code_i[15:8])
    && bank0_status[3:0] == $past(err0_code_i[3:0]))
    else $error("bank zero first code not captured");
  first1_code_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    log1_en && !bank1_status[mc_log_pkg::VAL_BIT]
    |=> bank1_status[15:8] == $past(err1_code_i[15:8])
    && bank1_status[3:0] == $past(err1_code_i[3:0]))
    else $error("bank one first code not captured");
  uc0_flag_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    log0_en && !bank0_status[mc_log_pkg::VAL_BIT]
    |=> bank0_status[mc_log_pkg::UC_BIT] == $past(err0_uc_i))
    else $error("bank zero class not captured");
  store0_code_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    log0_en && !bank0_status[mc_log_pkg::VAL_BIT]
    && err0_kind_i == mc_log_pkg::KIND_STORE
    |=> bank0_status[7:4] == mc_log_pkg::REQ_DATA_WRITE)
    else $error("bank zero store not logged as write");
  own1_code_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    log1_en && !bank1_status[mc_log_pkg::VAL_BIT]
    && err1_kind_i == mc_log_pkg::KIND_OWN_READ
    |=> bank1_status[7:4] == mc_log_pkg::REQ_DATA_READ)
    else $error("ownership read not logged as read");
  write1_code_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    log1_en && !bank1_status[mc_log_pkg::VAL_BIT] && err1_uc_i
    && err1_kind_i == mc_log_pkg::KIND_STORE
    |=> bank1_status[7:4] == mc_log_pkg::REQ_DATA_WRITE)
    else $error("write not logged as 0100b");
  spec_uc_log_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    err1_valid_i && err1_spec_i && err1_uc_i && ctrl[1]
    && !bank1_status[mc_log_pkg::VAL_BIT] |=> bank1_status[mc_log_pkg::UC_BIT])
    else $error("speculative uncorrectable not reported");
  // Interrupt and read path
  irq0_set_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    log0_en |=> irq_status[mc_log_pkg::IRQ_BANK0])
    else $error("bank zero event bit not set");
  irq1_set_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    log1_en |=> irq_status[mc_log_pkg::IRQ_BANK1])
    else $error("bank one event bit not set");
  rdata_idle_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    !reg_rd_i |=> reg_rdata_o == 64'h0)
    else $error("read data stands without a read");
  rdata0_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    reg_rd_i && reg_addr_i == mc_log_pkg::OFF_BANK0_STATUS
    |=> reg_rdata_o == $past(bank0_status))
    else $error("bank zero read data wrong");
  // A disabled bank must drop every report
  off0_skip_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    err0_valid_i && !ctrl[0] && !reg_wr_i |=> $stable(bank0_status))
    else $error("disabled bank zero logged");

endmodule : machine_check_error_log_bank

/* verification/machine_check_error_log_bank_tb.sv */
// Directed bench for the machine-check error logging banks
`timescale 1ns/1ps
module machine_check_error_log_bank_tb;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [63:0] wdata = 64'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [63:0] rdata;
  logic [2:0] v0 = 3'h0;
  logic [2:0] v1 = 3'h0;
  logic [2:0] k0 = 3'h0;
  logic [2:0] k1 = 3'h0;
  logic [15:0] c0 = 16'h0;
  logic [15:0] c1 = 16'h0;
  logic bus_req = 1'b0;
  logic bus_issue;
  logic irq;
  int err_count = 0;
  int total_checks = 0;

  machine_check_error_log_bank dut (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .err0_valid_i(v0[0]), .err0_uc_i(v0[1]),
    .err0_kind_i(k0), .err0_code_i(c0), .err1_valid_i(v1[0]),
    .err1_uc_i(v1[1]), .err1_spec_i(v1[2]), .err1_kind_i(k1),
    .err1_code_i(c1), .bus_req_i(bus_req), .bus_issue_o(bus_issue),
    .irq_o(irq));

  always #50 sys_clk = ~sys_clk;

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [3:0] a, input logic [63:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, input logic [63:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd_reg

  // Flags are {spec, uc, valid}; reports on either bank also check bus issue
  task automatic err(input bit bank, input logic [2:0] f,
                     input logic [2:0] k, input logic [15:0] c);
    @(posedge sys_clk);
    if (bank) begin
      v1 <= f;
      k1 <= k;
      c1 <= c;
    end else begin
      v0 <= f;
      k0 <= k;
      c0 <= c;
    end
    @(posedge sys_clk);
    #1;
    chk({63'h0, bus_issue}, 64'h1);
    v0 <= 3'h0;
    v1 <= 3'h0;
  endtask : err

  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  // Whole run needs about 80 cycles
  initial begin
    #(100 * 3000);
    err_count++;
    report_and_stop();
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    bus_req <= 1'b1;
    rd_reg(mc_log_pkg::OFF_BANK0_STATUS, mc_log_pkg::STATUS_RST);
    rd_reg(mc_log_pkg::OFF_CTRL, 64'h3);
    rd_reg(4'h5, 64'h0);
    wr_reg(4'h5, 64'hffff);
    rd_reg(4'h5, 64'h0);
    // Bank zero: correctable, then uncorrectable store, then more errors
    err(1'b0, 3'h1, mc_log_pkg::KIND_READ, 16'h00a1);
    rd_reg(mc_log_pkg::OFF_BANK0_STATUS, 64'h8000_0000_0000_0031);
    err(1'b0, 3'h3, mc_log_pkg::KIND_STORE, 16'hbee0);
    rd_reg(mc_log_pkg::OFF_BANK0_STATUS, 64'he000_0000_0000_be40);
    err(1'b0, 3'h1, mc_log_pkg::KIND_READ, 16'h0777);
    rd_reg(mc_log_pkg::OFF_BANK0_STATUS, 64'he000_0000_0000_be40);
    err(1'b0, 3'h3, mc_log_pkg::KIND_PREFETCH, 16'h1234);
    rd_reg(mc_log_pkg::OFF_BANK0_STATUS, 64'he000_0000_0000_be40);
    // Interrupt: set, masked, unmasked, cleared
    rd_reg(mc_log_pkg::OFF_IRQ_STATUS, 64'h1);
    chk({63'h0, irq}, 64'h0);
    wr_reg(mc_log_pkg::OFF_IRQ_MASK, 64'h3);
    #1;
    chk({63'h0, irq}, 64'h1);
    wr_reg(mc_log_pkg::OFF_IRQ_STATUS, 64'h1);
    rd_reg(mc_log_pkg::OFF_IRQ_STATUS, 64'h0);
    chk({63'h0, irq}, 64'h0);
    // Software clear makes the next error a fresh first one
    wr_reg(mc_log_pkg::OFF_BANK0_STATUS, 64'h0);
    rd_reg(mc_log_pkg::OFF_BANK0_STATUS, 64'h0);
    err(1'b0, 3'h1, mc_log_pkg::KIND_PREFETCH, 16'h0000);
    rd_reg(mc_log_pkg::OFF_BANK0_STATUS, 64'h8000_0000_0000_0050);
    // Bank one: speculative correctable load is not logged
    err(1'b1, 3'h5, mc_log_pkg::KIND_READ, 16'h1111);
    rd_reg(mc_log_pkg::OFF_BANK1_STATUS, 64'h0);
    err(1'b1, 3'h7, mc_log_pkg::KIND_READ, 16'h0000);
    rd_reg(mc_log_pkg::OFF_BANK1_STATUS, 64'ha000_0000_0000_0030);
    wr_reg(mc_log_pkg::OFF_BANK1_STATUS, 64'h0);
    err(1'b1, 3'h3, mc_log_pkg::KIND_STORE, 16'h0000);
    rd_reg(mc_log_pkg::OFF_BANK1_STATUS, 64'ha000_0000_0000_0040);
    // Ownership reads with correctable errors, bus must keep issuing
    wr_reg(mc_log_pkg::OFF_BANK1_STATUS, 64'h0);
    err(1'b1, 3'h1, mc_log_pkg::KIND_OWN_READ, 16'h0000);
    err(1'b1, 3'h1, mc_log_pkg::KIND_LOCKED_OWN_READ, 16'h0000);
    rd_reg(mc_log_pkg::OFF_BANK1_STATUS, 64'hc000_0000_0000_0030);
    rd_reg(mc_log_pkg::OFF_IRQ_STATUS, 64'h3);
    chk({63'h0, irq}, 64'h1);
    // Bank one disabled: a report must leave the record alone
    wr_reg(mc_log_pkg::OFF_CTRL, 64'h1);
    err(1'b1, 3'h3, mc_log_pkg::KIND_STORE, 16'hffff);
    rd_reg(mc_log_pkg::OFF_BANK1_STATUS, 64'hc000_0000_0000_0030);
    @(posedge sys_clk);
    bus_req <= 1'b0;
    #1;
    chk({63'h0, bus_issue}, 64'h0);
    report_and_stop();
  end
endmodule : machine_check_error_log_bank_tb
